// ---- verilog/lit_move_pkg.sv ----
// Purpose: constants for the literal/move/indirect/return execution block
// Assumes: 14-bit instruction words, 12-bit data and pointer space
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone
package lit_move_pkg;
	// register map (byte offsets)
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_WORK = 8'h04;
	localparam logic [7:0] OFF_BANK = 8'h08;
	localparam logic [7:0] OFF_PAGE = 8'h0c;
	localparam logic [7:0] OFF_PTR0 = 8'h10;
	localparam logic [7:0] OFF_PTR1 = 8'h14;
	localparam logic [7:0] OFF_OPTION = 8'h18;
	localparam logic [7:0] OFF_IRQCTL = 8'h1c;
	localparam logic [7:0] OFF_FLAGS = 8'h20;
	localparam logic [7:0] OFF_STATE = 8'h24;
	// widths and field positions
	localparam int INSTR_W = 14;
	localparam int PTR_W = 12;
	localparam int PC_W = 15;
	localparam int BANK_W = 5;
	localparam int PAGE_W = 7;
	localparam int GIE_BIT = 7;
	// reset values
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] IRQCTL_RST = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
	// fixed opcodes
	localparam logic [13:0] OPC_NOP = 14'h0000;
	localparam logic [13:0] OPC_RESET = 14'h0001;
	localparam logic [13:0] OPC_RETURN_IRQ = 14'h0009;
	localparam logic [13:0] OPC_OPTION = 14'h0062;
	// opcode prefixes
	localparam logic [6:0] PFX_STORE_DIRECT = 7'h01;
	localparam logic [8:0] PFX_LOAD_BANK = 9'h001;
	localparam logic [6:0] PFX_LOAD_PAGE = 7'h63;
	localparam logic [5:0] PFX_LOAD_WORK = 6'h30;
	localparam logic [10:0] PFX_STORE_IND_MODE = 11'h003;
	localparam logic [6:0] PFX_STORE_IND_OFS = 7'h7f;
	// pointer update modes
	localparam logic [1:0] MODE_PRE_INC = 2'h0;
	localparam logic [1:0] MODE_PRE_DEC = 2'h1;
	localparam logic [1:0] MODE_POST_INC = 2'h2;
	localparam logic [1:0] MODE_POST_DEC = 2'h3;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_LOAD_BANK = 4'h1,
		OP_LOAD_PAGE = 4'h2,
		OP_LOAD_WORK = 4'h3,
		OP_STORE_DIRECT = 4'h4,
		OP_STORE_IND_MODE = 4'h5,
		OP_STORE_IND_OFS = 4'h6,
		OP_OPTION = 4'h7,
		OP_RESET = 4'h8,
		OP_RETURN_IRQ = 4'h9,
		OP_UNKNOWN = 4'hf
	} op_e;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RETURN = 1'b1
	} state_e;
endpackage : lit_move_pkg

// ---- verilog/lit_move_exec.sv ----
// Purpose: executes literal loads, work stores, option load, software reset
//          and return from interrupt for an 8-bit core
// Assumes: software writes one instruction word at a time over Wishbone
// Notes: data memory and return stack sit outside; this block drives them
`timescale 1ns/100ps

// Contract
// - bank literal loads 5-bit field into bank selector, flags untouched
// - page literal loads 7-bit value into pc upper latch, flags untouched
// - work literal loads 8-bit value into work register in one cycle
// - direct store writes work register to bank-selected 7-bit address
// - indirect store writes work to address from pointer 0 or 1
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec of pointer
// - offset form addresses pointer plus signed -32..31, pointer unchanged
// - pointer increment and decrement wrap around modulo the pointer range
// - pointer updates never change any status flag
// - option load copies work register into option register, flags kept
// - software reset instruction resets all block state like hardware, except the Wishbone answer and the two soft reset flops
// - return from irq pops stack and loads its top into program counter
// - return from irq sets global irq enable, bit 7 of irq control
// - return from irq takes two instruction cycles, one word
module lit_move_exec (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// data memory write port
	output logic dmem_we_o,
	output logic [lit_move_pkg::PTR_W-1:0] dmem_addr_o,
	output logic [7:0] dmem_data_o,
	// return stack
	input wire logic [lit_move_pkg::PC_W-1:0] stack_top_i,
	output logic stack_pop_o,
	output logic [lit_move_pkg::PC_W-1:0] pc_o,
	// core state seen by the rest of the device
	output logic [lit_move_pkg::BANK_W-1:0] bank_o,
	output logic [lit_move_pkg::PAGE_W-1:0] page_latch_o,
	output logic [7:0] option_o,
	output logic global_irq_enable_o,
	output logic soft_reset_o
);

	function automatic lit_move_pkg::op_e decode(
		input logic [lit_move_pkg::INSTR_W-1:0] ins);
		lit_move_pkg::op_e op;
		op = lit_move_pkg::OP_UNKNOWN;
		if (ins == lit_move_pkg::OPC_NOP) begin
			op = lit_move_pkg::OP_NOP;
		end else if (ins == lit_move_pkg::OPC_RESET) begin
			op = lit_move_pkg::OP_RESET;
		end else if (ins == lit_move_pkg::OPC_RETURN_IRQ) begin
			op = lit_move_pkg::OP_RETURN_IRQ;
		end else if (ins == lit_move_pkg::OPC_OPTION) begin
			op = lit_move_pkg::OP_OPTION;
		end else if (ins[13:7] == lit_move_pkg::PFX_STORE_DIRECT) begin
			op = lit_move_pkg::OP_STORE_DIRECT;
		end else if (ins[13:5] == lit_move_pkg::PFX_LOAD_BANK) begin
			op = lit_move_pkg::OP_LOAD_BANK;
		end else if (ins[13:7] == lit_move_pkg::PFX_LOAD_PAGE) begin
			op = lit_move_pkg::OP_LOAD_PAGE;
		end else if (ins[13:8] == lit_move_pkg::PFX_LOAD_WORK) begin
			op = lit_move_pkg::OP_LOAD_WORK;
		end else if (ins[13:3] == lit_move_pkg::PFX_STORE_IND_MODE) begin
			op = lit_move_pkg::OP_STORE_IND_MODE;
		end else if (ins[13:7] == lit_move_pkg::PFX_STORE_IND_OFS) begin
			op = lit_move_pkg::OP_STORE_IND_OFS;
		end
		return op;
	endfunction : decode

	// one step of the pointer; the 12-bit sum drops its carry so it wraps
	function automatic logic [lit_move_pkg::PTR_W-1:0] step(
		input logic [lit_move_pkg::PTR_W-1:0] p,
		input logic down);
		logic [lit_move_pkg::PTR_W-1:0] r;
		r = down ? p - 12'h001 : p + 12'h001;
		return r;
	endfunction : step

	// architectural state
	logic [7:0] work;
	logic [lit_move_pkg::PTR_W-1:0] ptr [2];
	logic [7:0] irq_control;
	logic [7:0] flags;
	logic [lit_move_pkg::INSTR_W-1:0] last_instr;
	lit_move_pkg::state_e state;
	logic soft_rst_q;
	logic rst_all;

	// bus access decode
	logic access;
	logic wr;
	logic exec;
	lit_move_pkg::op_e op;
	logic [lit_move_pkg::INSTR_W-1:0] ins;
	logic sel_n;
	logic [1:0] mode;
	logic [lit_move_pkg::PTR_W-1:0] ofs;
	logic [lit_move_pkg::PTR_W-1:0] ind_addr;
	logic [lit_move_pkg::PTR_W-1:0] next_ptr;
	logic [31:0] rd_word;

	// one strobe per instruction other than no-operation, high only for the edge that executes it
	logic do_bank;
	logic do_page;
	logic do_work;
	logic do_direct;
	logic do_ind_mode;
	logic do_ind_ofs;
	logic do_option;
	logic do_reset;
	logic do_return;

	// software reset goes through a flop so the ack of its write still lands
	assign rst_all = rst_i | soft_rst_q;
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// only select bit 0 gates writes; instruction and pointer data also use lane 1, lanes 2 and 3 are don't-care
	assign wr = access & wb_we_i & wb_sel_i[0];
	// a word written while a return is still busy is acked and dropped
	assign exec = wr & (wb_adr_i == lit_move_pkg::OFF_INSTR) &
		(state == lit_move_pkg::ST_IDLE);
	assign ins = wb_dat_i[lit_move_pkg::INSTR_W-1:0];
	assign op = decode(ins);

	assign do_bank = exec & (op == lit_move_pkg::OP_LOAD_BANK);
	assign do_page = exec & (op == lit_move_pkg::OP_LOAD_PAGE);
	assign do_work = exec & (op == lit_move_pkg::OP_LOAD_WORK);
	assign do_direct = exec & (op == lit_move_pkg::OP_STORE_DIRECT);
	assign do_ind_mode = exec & (op == lit_move_pkg::OP_STORE_IND_MODE);
	assign do_ind_ofs = exec & (op == lit_move_pkg::OP_STORE_IND_OFS);
	assign do_option = exec & (op == lit_move_pkg::OP_OPTION);
	assign do_reset = exec & (op == lit_move_pkg::OP_RESET);
	assign do_return = exec & (op == lit_move_pkg::OP_RETURN_IRQ);

	// indirect addressing
	always_comb begin
		sel_n = (op == lit_move_pkg::OP_STORE_IND_OFS) ? ins[6] : ins[2];
		mode = ins[1:0];
		ofs = {{6{ins[5]}}, ins[5:0]};
		next_ptr = ptr[sel_n];
		ind_addr = ptr[sel_n];
		if (op == lit_move_pkg::OP_STORE_IND_OFS) begin
			ind_addr = ptr[sel_n] + ofs;
		end else begin
			next_ptr = step(ptr[sel_n], mode[0]);
			if (mode == lit_move_pkg::MODE_PRE_INC ||
				mode == lit_move_pkg::MODE_PRE_DEC) begin
				ind_addr = next_ptr;
			end
		end
	end

	// read mux; reads have no side effects, so it may follow the address
	always_comb begin
		case (wb_adr_i)
		lit_move_pkg::OFF_INSTR: rd_word = {18'h0, last_instr};
		lit_move_pkg::OFF_WORK: rd_word = {24'h0, work};
		lit_move_pkg::OFF_BANK: rd_word = {27'h0, bank_o};
		lit_move_pkg::OFF_PAGE: rd_word = {25'h0, page_latch_o};
		lit_move_pkg::OFF_PTR0: rd_word = {20'h0, ptr[0]};
		lit_move_pkg::OFF_PTR1: rd_word = {20'h0, ptr[1]};
		lit_move_pkg::OFF_OPTION: rd_word = {24'h0, option_o};
		lit_move_pkg::OFF_IRQCTL: rd_word = {24'h0, irq_control};
		lit_move_pkg::OFF_FLAGS: rd_word = {24'h0, flags};
		lit_move_pkg::OFF_STATE:
			rd_word = {16'h0, pc_o, state == lit_move_pkg::ST_RETURN};
		default: rd_word = 32'h0;
		endcase
	end

	// wishbone answer: one wait state, ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			last_instr <= lit_move_pkg::OPC_NOP;
		end else if (exec) begin
			last_instr <= ins;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			work <= lit_move_pkg::WORK_RST;
		end else if (do_work) begin
			work <= ins[7:0];
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_WORK) begin
			work <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			bank_o <= '0;
		end else if (do_bank) begin
			bank_o <= ins[4:0];
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_BANK) begin
			bank_o <= wb_dat_i[4:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			page_latch_o <= '0;
		end else if (do_page) begin
			page_latch_o <= ins[6:0];
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_PAGE) begin
			page_latch_o <= wb_dat_i[6:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			option_o <= lit_move_pkg::OPTION_RST;
		end else if (do_option) begin
			option_o <= work;
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_OPTION) begin
			option_o <= wb_dat_i[7:0];
		end
	end

	// pointers: offset form leaves the pointer alone
	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			ptr[0] <= lit_move_pkg::PTR_RST;
			ptr[1] <= lit_move_pkg::PTR_RST;
		end else if (do_ind_mode) begin
			ptr[sel_n] <= next_ptr;
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_PTR0) begin
			ptr[0] <= wb_dat_i[lit_move_pkg::PTR_W-1:0];
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_PTR1) begin
			ptr[1] <= wb_dat_i[lit_move_pkg::PTR_W-1:0];
		end
	end

	// status flags change only by bus write or reset; of the instructions, only software reset touches them
	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			flags <= 8'h00;
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_FLAGS) begin
			flags <= wb_dat_i[7:0];
		end
	end

	// data memory writes; the indirect window has no storage of its own
	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			dmem_we_o <= 1'b0;
			dmem_addr_o <= '0;
			dmem_data_o <= 8'h00;
		end else begin
			dmem_we_o <= 1'b0;
			if (do_direct) begin
				dmem_we_o <= 1'b1;
				// the bank fills the upper address bits of a direct store
				dmem_addr_o <= {bank_o, ins[6:0]};
				dmem_data_o <= work;
			end else if (do_ind_mode || do_ind_ofs) begin
				dmem_we_o <= 1'b1;
				dmem_addr_o <= ind_addr;
				dmem_data_o <= work;
			end
		end
	end

	// return from irq: cycle one decodes, cycle two pops and loads
	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			state <= lit_move_pkg::ST_IDLE;
			stack_pop_o <= 1'b0;
			pc_o <= '0;
		end else begin
			stack_pop_o <= 1'b0;
			case (state)
			lit_move_pkg::ST_IDLE: begin
				if (do_return) begin
					state <= lit_move_pkg::ST_RETURN;
				end
			end
			lit_move_pkg::ST_RETURN: begin
				// stack top is taken here, a cycle after the word was acked
				stack_pop_o <= 1'b1;
				pc_o <= stack_top_i;
				state <= lit_move_pkg::ST_IDLE;
			end
			default: state <= lit_move_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			irq_control <= lit_move_pkg::IRQCTL_RST;
		end else if (state == lit_move_pkg::ST_RETURN) begin
			irq_control[lit_move_pkg::GIE_BIT] <= 1'b1;
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_IRQCTL) begin
			irq_control <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			global_irq_enable_o <= 1'b0;
		end else if (state == lit_move_pkg::ST_RETURN) begin
			global_irq_enable_o <= 1'b1;
		end else if (wr && wb_adr_i == lit_move_pkg::OFF_IRQCTL) begin
			global_irq_enable_o <= wb_dat_i[lit_move_pkg::GIE_BIT];
		end
	end

	// no-operation and unknown words only update last_instr; every other block above ignores them
	// only the pin reset clears this, so a soft reset cannot hold itself on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_rst_q <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			soft_rst_q <= do_reset;
			soft_reset_o <= do_reset;
		end
	end

endmodule : lit_move_exec

// ---- verif/lit_move_exec_properties.sv ----
// Purpose: port-level properties of the literal/move/return exec block
// Assumes: one clock, one Wishbone access at a time
// Notes: load and store effects show one edge after the write is taken, return and soft reset effects two
`timescale 1ns/100ps
module lit_move_exec_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// memory and stack
	input wire logic dmem_we_o,
	input wire logic [lit_move_pkg::PTR_W-1:0] dmem_addr_o,
	input wire logic [lit_move_pkg::PC_W-1:0] stack_top_i,
	input wire logic stack_pop_o,
	input wire logic [lit_move_pkg::PC_W-1:0] pc_o,
	// core state
	input wire logic [lit_move_pkg::BANK_W-1:0] bank_o,
	input wire logic [lit_move_pkg::PAGE_W-1:0] page_latch_o,
	input wire logic [7:0] option_o,
	input wire logic global_irq_enable_o,
	input wire logic soft_reset_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic tk;
	logic iw;
	logic [13:0] ins;
	logic rw;
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign iw = tk && wb_we_i && wb_adr_i == lit_move_pkg::OFF_INSTR;
	assign ins = wb_dat_i[13:0];
	assign rw = iw && ins == lit_move_pkg::OPC_RETURN_IRQ;
	sequence s_ret;
		rw;
	endsequence
	sequence s_ret_done;
		!stack_pop_o ##1
		(stack_pop_o && global_irq_enable_o && pc_o == $past(stack_top_i));
	endsequence
	sequence s_sr;
		iw && ins == lit_move_pkg::OPC_RESET;
	endsequence
	property p_ack;
		tk |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_dat;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat: assert property (p_dat) else $error("read data without ack");
	property p_bank;
		iw && ins[13:5] == lit_move_pkg::PFX_LOAD_BANK
			|=> bank_o == $past(ins[4:0]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank load");
	property p_page;
		iw && ins[13:7] == lit_move_pkg::PFX_LOAD_PAGE
			|=> page_latch_o == $past(ins[6:0]);
	endproperty
	a_page: assert property (p_page) else $error("page load");
	property p_direct;
		iw && ins[13:7] == lit_move_pkg::PFX_STORE_DIRECT |=> dmem_we_o
			&& dmem_addr_o == {$past(bank_o), $past(ins[6:0])};
	endproperty
	a_direct: assert property (p_direct) else $error("direct");
	property p_ind;
		iw && ins[13:3] == lit_move_pkg::PFX_STORE_IND_MODE
			|=> dmem_we_o ##1 !dmem_we_o;
	endproperty
	a_ind: assert property (p_ind) else $error("indirect");
	property p_ofs;
		iw && ins[13:7] == lit_move_pkg::PFX_STORE_IND_OFS |=> dmem_we_o;
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset store");
	property p_ret;
		s_ret |=> s_ret_done;
	endproperty
	a_ret: assert property (p_ret) else $error("return");
	property p_pop;
		stack_pop_o |-> $past(rw, 2);
	endproperty
	a_pop: assert property (p_pop) else $error("stray pop");
	property p_sr;
		s_sr |=> soft_reset_o ##1 (bank_o == 5'h00 && page_latch_o == 7'h00
			&& option_o == lit_move_pkg::OPTION_RST && pc_o == 15'h0000
			&& !global_irq_enable_o);
	endproperty
	a_sr: assert property (p_sr) else $error("soft reset");
	property p_nop;
		iw && ins == lit_move_pkg::OPC_NOP |=> (!dmem_we_o && !stack_pop_o
			&& $stable(bank_o) && $stable(page_latch_o) && $stable(option_o)
			&& $stable(pc_o))[*2];
	endproperty
	a_nop: assert property (p_nop) else $error("nop side effect");
endmodule : lit_move_exec_checker

bind lit_move_exec lit_move_exec_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .dmem_we_o(dmem_we_o), .dmem_addr_o(dmem_addr_o),
	.stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .pc_o(pc_o),
	.bank_o(bank_o), .page_latch_o(page_latch_o), .option_o(option_o),
	.global_irq_enable_o(global_irq_enable_o), .soft_reset_o(soft_reset_o));

// ---- verif/dmem_stack_model.sv ----
// Purpose: data memory and return stack beside the exec block
// Assumes: write and pop are one-cycle pulses
// Notes: an empty stack shows the inverse of the last top, not a copy
`timescale 1ns/100ps
module dmem_stack_model (
	// clock
	input wire logic clk_i,
	// data memory write
	input wire logic we_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] data_i,
	// return stack
	input wire logic pop_i,
	output logic [14:0] top_o
);
	logic [7:0] mem [4096];
	logic [14:0] stk [16];
	logic [14:0] last = 15'h0000;
	// pushes and pops are counted apart so each count has a single writer
	int n_push = 0;
	int n_pop = 0;
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= data_i;
		end
		if (pop_i && n_push > n_pop) begin
			last <= stk[n_push-n_pop-1];
			n_pop <= n_pop + 1;
		end
	end
	assign top_o = n_push > n_pop ? stk[n_push-n_pop-1] : ~last;
	task automatic push(input logic [14:0] v);
		stk[n_push-n_pop] = v;
		n_push = n_push + 1;
	endtask : push
endmodule : dmem_stack_model

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the literal/move/return exec block
// Assumes: instruction words are written at offset 00
// Notes: an integer model predicts work, bank, page, pointers, option, gie and pc after each instruction
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0, dat_o;
	logic ack, dwe, pop, global_irq_enable, srst;
	logic [11:0] daddr;
	logic [7:0] ddat, opt;
	logic [14:0] top, pc;
	logic [4:0] bank_o;
	logic [6:0] page_o;
	int num_errors = 0, compares = 0;
	int srst_seen = 0, pops_seen = 0, stores_seen = 0;
	int pops_exp = 0, stores_exp = 0;
	int work, bank, page, opt_m, gie_m, pc_m;
	int ptr [2];
	always #20 clk_i = ~clk_i;
	// pulse outputs are counted here so that none of them goes unchecked
	always @(posedge clk_i) begin
		if (srst === 1'b1) srst_seen++;
		if (pop === 1'b1) pops_seen++;
		if (dwe === 1'b1) stores_seen++;
	end
	lit_move_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .dmem_we_o(dwe),
		.dmem_addr_o(daddr), .dmem_data_o(ddat), .stack_top_i(top),
		.stack_pop_o(pop), .pc_o(pc), .bank_o(bank_o), .page_latch_o(page_o),
		.option_o(opt), .global_irq_enable_o(global_irq_enable), .soft_reset_o(srst));
	dmem_stack_model i_mem (.clk_i(clk_i), .we_i(dwe), .addr_i(daddr),
		.data_i(ddat), .pop_i(pop), .top_o(top));
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// no limit here: only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic reset_model();
		work = 0;
		bank = 0;
		page = 0;
		ptr = '{0, 0};
		opt_m = 'hff;
		gie_m = 0;
		pc_m = 0;
	endtask : reset_model
	task automatic chk_all();
		logic [31:0] q;
		chk(bank_o, bank);
		chk(page_o, page);
		chk(opt, opt_m);
		chk(global_irq_enable, gie_m);
		chk(pc, pc_m);
		wb(1'b0, lit_move_pkg::OFF_WORK, 0, q);
		chk(q, work);
		wb(1'b0, lit_move_pkg::OFF_PTR0, 0, q);
		chk(q, ptr[0]);
		wb(1'b0, lit_move_pkg::OFF_PTR1, 0, q);
		chk(q, ptr[1]);
	endtask : chk_all
	task automatic ex(input logic [13:0] i);
		logic [31:0] q;
		int n, a, s;
		a = -1;
		n = i[2];
		s = i[0] ? -1 : 1;
		casez (i)
			14'b00_0000_001?_????: bank = i[4:0];
			14'b11_0001_1???_????: page = i[6:0];
			14'b11_0000_????_????: work = i[7:0];
			14'b00_0000_1???_????: a = bank * 128 + i[6:0];
			14'b00_0000_0001_1???: begin
				if (!i[1]) ptr[n] = (ptr[n] + s) & 'hfff;
				a = ptr[n];
				if (i[1]) ptr[n] = (ptr[n] + s) & 'hfff;
			end
			14'b11_1111_1???_????:
				a = (ptr[i[6]] + int'($signed(i[5:0]))) & 'hfff;
			lit_move_pkg::OPC_OPTION: opt_m = work;
			lit_move_pkg::OPC_RETURN_IRQ: begin
				pc_m = $urandom_range(32767);
				i_mem.push(pc_m[14:0]);
				gie_m = 1;
				pops_exp++;
			end
			default: ;
		endcase
		wb(1'b1, lit_move_pkg::OFF_INSTR, {18'h0, i}, q);
		if (i == lit_move_pkg::OPC_RESET)
			reset_model();
		if (a >= 0) begin
			stores_exp++;
			chk(daddr, a);
			chk(i_mem.mem[a], work);
		end
		chk_all();
	endtask : ex
	initial begin
		#(40 * 20000);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] q, f;
		int k;
		k = $urandom(20);
		reset_model();
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_all();
		wb(1'b1, 8'h40, $urandom, q);
		wb(1'b0, 8'h40, 0, q);
		chk(q, 0);
		$display("reset and unmapped test done");
		f = $urandom;
		wb(1'b1, lit_move_pkg::OFF_FLAGS, f, q);
		wb(1'b0, lit_move_pkg::OFF_FLAGS, 0, q);
		chk(q, {24'h0, f[7:0]});
		// boundary pointers first so every mode crosses a wrap
		for (k = 0; k < 8; k++) begin
			wb(1'b1, lit_move_pkg::OFF_PTR0, k[0] ? 0 : 'hfff, q);
			wb(1'b1, lit_move_pkg::OFF_PTR1, k[0] ? 0 : 'hfff, q);
			ptr[0] = k[0] ? 0 : 'hfff;
			ptr[1] = ptr[0];
			ex({6'h30, 8'($urandom)});
			ex({11'h003, k[2:0]});
		end
		ex({7'h7f, 7'h20});
		ex({7'h7f, 7'h5f});
		$display("pointer mode test done");
		repeat (80) begin
			q = $urandom;
			case ($urandom_range(8))
				0: ex({9'h001, 1'b0, q[3:0]});
				1: ex({7'h63, q[6:0]});
				2: ex({6'h30, q[7:0]});
				3: ex({7'h01, q[6:0]});
				4: ex({11'h003, q[2:0]});
				5: ex({7'h7f, q[6:0]});
				6: ex(lit_move_pkg::OPC_OPTION);
				7: ex(lit_move_pkg::OPC_RETURN_IRQ);
				default: begin
					wb(1'b1, lit_move_pkg::OFF_IRQCTL, 0, q);
					gie_m = 0;
					ex(lit_move_pkg::OPC_NOP);
				end
			endcase
		end
		wb(1'b0, lit_move_pkg::OFF_FLAGS, 0, q);
		chk(q, {24'h0, f[7:0]});
		$display("random instruction test done");
		ex(lit_move_pkg::OPC_RESET);
		chk(srst_seen, 1);
		chk(pops_seen, pops_exp);
		chk(stores_seen, stores_exp);
		$display("software reset test done");
		tally_and_finish();
	end
endmodule : tb_top
